// ===== serial_adc_cfg.svh
// constants for the serial converter channel control block
// assumes it is included by the package and by the top module; guarded
//
// Overview of operation
// - eighth shift falling edge in a frame starts a 36-cycle conversion on the stored channel
// - debounced chip select low puts the previous result's most significant bit out before the first shift edge
// - first seven shift falling edges put out bits 6 down to 0
// - chip select changes are ignored until stable for three conversion clocks
// - twenty-way selector picks one of 19 inputs or the self-test voltage
// - sample and hold runs automatically or under host control
// - three-state serial output plus conversion clock, shift clock, chip select, address
// - next address shifts in during the frame that shifts the last result out
// - result is eight bits built by successive approximation, one bit per step
`ifndef SERIAL_ADC_CFG_SVH
`define SERIAL_ADC_CFG_SVH

`define ADC_RES_W 8
`define ADC_ADDR_W 5
`define ADC_CNT_W 5
`define ADC_CYC_W 6
`define ADC_FRAME_BITS 5'h08
`define ADC_CONV_CYCLES 36
`define ADC_CONV_LAST 6'h23
`define ADC_SAMPLE_LAST 6'h03
`define ADC_STEP_END 2'h3
`define ADC_DEB_LAST 2'h2
`define ADC_EXT_INPUTS 5'h13
`define ADC_TRIAL_MSB 8'h80
`define ADC_MSB_IDX 3'h7

`endif

// ===== serial_adc_pkg.sv
// types shared by the serial converter control block
// assumes the constants header sits in the same folder
`include "serial_adc_cfg.svh"

package serial_adc_pkg;

    typedef logic [`ADC_RES_W-1:0] result_t;
    typedef logic [`ADC_CNT_W-1:0] edge_cnt_t;

    // selected analog source: external input number or the self-test voltage
    typedef struct packed {
        logic [`ADC_ADDR_W-1:0] chan;
        logic selftest;
    } chan_sel_t;

    // conversion sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SAMPLE = 4'h2,
        ST_STEP = 4'h4,
        ST_DONE = 4'h8
    } conv_state_t;

endpackage : serial_adc_pkg

// ===== serial_adc_ctl.sv
// serial converter channel control: frame debounce, shift port, SAR sequencer
// assumes ref_clk_i is the conversion clock and io_clk_i the host shift clock,
// the shift clock being quiet between frames; analog parts sit outside
`timescale 1ns/1ps
`include "serial_adc_cfg.svh"

// two-entry result buffer between the sequencer and the shift port
module result_fifo2 #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [1:0] count_r, count_nxt;
    logic push, pop;

    // honest full and empty flags from the occupancy count
    always_comb begin
        in_ready_o = (count_r != 2'h2);
        out_valid_o = (count_r != 2'h0);
        out_data_o = mem_r[rd_ptr_r];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        mem_nxt = mem_r;
        if (push) begin
            mem_nxt[wr_ptr_r] = in_data_i;
        end
        wr_ptr_nxt = push ? ~wr_ptr_r : wr_ptr_r;
        rd_ptr_nxt = pop ? ~rd_ptr_r : rd_ptr_r;
        count_nxt = count_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule : result_fifo2

module serial_adc_ctl
    import serial_adc_pkg::*;
(
    // conversion clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // host shift port
    input wire logic io_clk_i,
    input wire logic cs_n_i,
    input wire logic addr_in_i,
    output logic data_o,
    output logic data_oe_o,
    // analog side
    input wire logic comp_i,
    input wire logic sh_host_mode_i,
    output chan_sel_t chan_o,
    output logic sample_o,
    output result_t dac_code_o,
    output logic busy_o
);
    // ---------------- link domain (shift clock) ----------------
    logic io_rst_n_s1, io_rst_n_s2;
    edge_cnt_t fall_cnt_r, fall_cnt_nxt, fall_gray_r, fall_gray_nxt;
    result_t addr_sh_r, addr_sh_nxt;

    // reset brought into the shift clock domain
    always_ff @(posedge io_clk_i) begin
        io_rst_n_s1 <= rst_n_i;
        io_rst_n_s2 <= io_rst_n_s1;
    end

    // free-running falling edge count; frames are measured against a base
    always_comb begin
        fall_cnt_nxt = io_rst_n_s2 ? fall_cnt_r + 5'h01 : 5'h00;
        fall_gray_nxt = fall_cnt_nxt ^ (fall_cnt_nxt >> 1);
    end

    always_ff @(negedge io_clk_i) begin
        fall_cnt_r <= fall_cnt_nxt;
        fall_gray_r <= fall_gray_nxt;
    end

    // address bits enter on rising edges, first bit ends up on top
    always_comb begin
        addr_sh_nxt = io_rst_n_s2 ? {addr_sh_r[6:0], addr_in_i} : 8'h00;
    end

    always_ff @(posedge io_clk_i) begin
        addr_sh_r <= addr_sh_nxt;
    end

    // ---------------- conversion clock domain ----------------
    logic cs_n_s1, cs_n_s2, comp_s1, comp_s2, mode_s1, mode_s2;
    edge_cnt_t gray_s1, gray_s2, io_cnt_s;
    result_t addr_s1, addr_s2;

    // two-stage synchronisers for pins and link-domain words
    always_ff @(posedge ref_clk_i) begin
        cs_n_s1 <= cs_n_i;
        cs_n_s2 <= cs_n_s1;
        comp_s1 <= comp_i;
        comp_s2 <= comp_s1;
        mode_s1 <= sh_host_mode_i;
        mode_s2 <= mode_s1;
        gray_s1 <= fall_gray_r;
        gray_s2 <= gray_s1;
        addr_s1 <= addr_sh_r;
        addr_s2 <= addr_s1;
    end

    // gray to binary of the synchronised edge count
    always_comb begin
        io_cnt_s[`ADC_CNT_W-1] = gray_s2[`ADC_CNT_W-1];
        for (int i = `ADC_CNT_W - 2; i >= 0; i--) begin
            io_cnt_s[i] = io_cnt_s[i+1] ^ gray_s2[i];
        end
    end

    // chip select filter and frame bookkeeping
    logic frame_r, frame_nxt, started_r, started_nxt, frame_start, conv_start;
    logic [1:0] deb_cnt_r, deb_cnt_nxt;
    edge_cnt_t base_r, base_nxt, rel_cnt;
    result_t hold_r, hold_nxt, fifo_data;
    logic fifo_valid, push_valid, push_ready;
    conv_state_t state_r, state_nxt;

    always_comb begin
        frame_nxt = frame_r;
        deb_cnt_nxt = 2'h0;
        if (!cs_n_s2 != frame_r) begin
            // noise shorter than three clocks never reaches the frame
            if (deb_cnt_r == `ADC_DEB_LAST) begin
                frame_nxt = !cs_n_s2;
            end else begin
                deb_cnt_nxt = deb_cnt_r + 2'h1;
            end
        end
        frame_start = frame_nxt && !frame_r;
        rel_cnt = io_cnt_s - base_r;
        conv_start = frame_r && !started_r && (rel_cnt == `ADC_FRAME_BITS) && (state_r == ST_IDLE);
        base_nxt = frame_start ? io_cnt_s : base_r;
        hold_nxt = (frame_start && fifo_valid) ? fifo_data : hold_r;
        started_nxt = frame_start ? 1'b0 : (started_r || (frame_r && rel_cnt == `ADC_FRAME_BITS));
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            frame_r <= 1'b0;
            deb_cnt_r <= 2'h0;
            base_r <= 5'h00;
            hold_r <= 8'h00;
            started_r <= 1'b1;
        end else begin
            frame_r <= frame_nxt;
            deb_cnt_r <= deb_cnt_nxt;
            base_r <= base_nxt;
            hold_r <= hold_nxt;
            started_r <= started_nxt;
        end
    end

    // serial output: base and hold are steady all frame, so the link edge
    // count selects the bit without waiting for a synchroniser
    edge_cnt_t out_idx;
    always_comb begin
        out_idx = fall_cnt_r - base_r;
        data_o = 1'b0;
        if (out_idx < `ADC_FRAME_BITS) begin
            data_o = hold_r[`ADC_MSB_IDX - out_idx[2:0]];
        end
    end
    assign data_oe_o = frame_r;

    // SAR sequencer
    logic [`ADC_CYC_W-1:0] cyc_r, cyc_nxt;
    logic [2:0] bit_r, bit_nxt;
    result_t code_r, code_nxt;
    chan_sel_t chan_r, chan_nxt;
    logic sample_r, sample_nxt, busy_r, busy_nxt;

    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        bit_nxt = bit_r;
        code_nxt = code_r;
        chan_nxt = chan_r;
        push_valid = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (conv_start) begin
                    state_nxt = ST_SAMPLE;
                    cyc_nxt = 6'h00;
                    code_nxt = 8'h00;
                    // codes past the last external input pick the self-test voltage
                    if (addr_s2[7:3] < `ADC_EXT_INPUTS) begin
                        chan_nxt = '{chan: addr_s2[7:3], selftest: 1'b0};
                    end else begin
                        chan_nxt = '{chan: 5'h00, selftest: 1'b1};
                    end
                end
            end
            ST_SAMPLE: begin
                cyc_nxt = cyc_r + 6'h01;
                if (cyc_r == `ADC_SAMPLE_LAST) begin
                    state_nxt = ST_STEP;
                    code_nxt = `ADC_TRIAL_MSB;
                    bit_nxt = `ADC_MSB_IDX;
                end
            end
            ST_STEP: begin
                cyc_nxt = cyc_r + 6'h01;
                // decide one bit at the end of each four-clock step
                if (cyc_r[1:0] == `ADC_STEP_END) begin
                    if (!comp_s2) begin
                        code_nxt[bit_r] = 1'b0;
                    end
                    if (bit_r != 3'h0) begin
                        code_nxt[bit_r - 3'h1] = 1'b1;
                        bit_nxt = bit_r - 3'h1;
                    end
                end
                if (cyc_r == `ADC_CONV_LAST) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // a full buffer stalls here rather than dropping the result
                push_valid = 1'b1;
                if (push_ready) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // host mode samples from frame start to the eighth edge; auto mode in its window
        if (mode_s2) begin
            sample_nxt = frame_r && !started_r && (state_r == ST_IDLE);
        end else begin
            sample_nxt = (state_nxt == ST_SAMPLE);
        end
        busy_nxt = (state_nxt != ST_IDLE);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            cyc_r <= 6'h00;
            bit_r <= 3'h0;
            code_r <= 8'h00;
            chan_r <= '{chan: 5'h00, selftest: 1'b0};
            sample_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            bit_r <= bit_nxt;
            code_r <= code_nxt;
            chan_r <= chan_nxt;
            sample_r <= sample_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign chan_o = chan_r;
    assign sample_o = sample_r;
    assign dac_code_o = code_r;
    assign busy_o = busy_r;

    result_fifo2 #(.W(`ADC_RES_W)) u_result_fifo (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(code_r),
        .out_valid_o(fifo_valid),
        .out_ready_i(frame_start),
        .out_data_o(fifo_data)
    );

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence cs_high_seq;
        cs_n_s2 [*4];
    endsequence

    sequence conv_begin_seq;
        conv_start ##1 (state_r == ST_SAMPLE && cyc_r == 6'h00);
    endsequence

    AST_CONV_LENGTH: assert property (conv_begin_seq |-> ##36 (state_r == ST_DONE))
        else $error("conversion did not last 36 clocks");
    AST_MSB_FIRST: assert property ($rose(data_oe_o) |-> data_o == hold_r[7])
        else $error("msb not presented at frame start");
    AST_DEBOUNCE: assert property ($changed(frame_r) |-> ($past(!cs_n_s2, 1) == frame_r)
        && ($past(!cs_n_s2, 2) == frame_r) && ($past(!cs_n_s2, 3) == frame_r))
        else $error("frame changed before chip select was stable");
    AST_FLOAT_IDLE: assert property (cs_high_seq |=> !data_oe_o)
        else $error("output driven while chip select high");
    AST_CHAN_LATCH: assert property (conv_start && addr_s2[7:3] < 5'h13 |=> chan_o.chan == $past(addr_s2[7:3])
        && !chan_o.selftest)
        else $error("channel address not taken at conversion start");
    AST_SELFTEST: assert property (conv_start && addr_s2[7:3] >= 5'h13 |=> chan_o.selftest)
        else $error("self-test source not selected");
    AST_SAR_CLEAR: assert property (state_r == ST_STEP && cyc_r[1:0] == 2'h3 && !comp_s2
        |=> !dac_code_o[$past(bit_r)])
        else $error("rejected trial bit kept");
    AST_AUTO_HOLD: assert property (!mode_s2 && state_r == ST_STEP && $past(state_r) == ST_STEP |-> !sample_o)
        else $error("sampling during approximation");
    AST_NO_LOSS: assert property (state_r == ST_DONE && !push_ready |=> state_r == ST_DONE && $stable(code_r))
        else $error("result dropped while buffer full");

endmodule : serial_adc_ctl

// ===== host_model.sv
// host side of the serial shift port: chip select, shift clock, address
// assumes ref_clk_i is the conversion clock; shift clock only runs in frames
// and around reset, where the io side needs edges to follow rst_n_i
`timescale 1ns/1ps
module host_model (
    // conversion clock and the resolved result line
    input wire logic ref_clk_i,
    input wire logic data_i,
    // shift port driven towards the device
    output logic io_clk_o,
    output logic cs_n_o,
    output logic addr_o
);
    int idle_cnt;
    initial begin
        io_clk_o = 1'b0;
        cs_n_o = 1'b1;
        addr_o = 1'b0;
        idle_cnt = 0;
    end
    // cycles spent deselected, so a conversion is never cut short
    always @(posedge ref_clk_i) idle_cnt <= cs_n_o ? idle_cnt + 1 : 0;
    // the io side resets from a synchronised copy, so it needs edges
    task reset_clk();
        repeat (4) begin
            #80 io_clk_o = 1'b1;
            #80 io_clk_o = 1'b0;
        end
    endtask : reset_clk
    task frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'hXX;
        while (idle_cnt < 50) @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        #37 rx[7] = data_i;
        for (int i = 0; i < n; i++) begin
            addr_o = tx[7-i];
            #80 io_clk_o = 1'b1;
            #80 io_clk_o = 1'b0;
            #20 if (i < 7) rx[6-i] = data_i;
        end
        addr_o = ~addr_o;
        @(posedge ref_clk_i) cs_n_o <= 1'b1;
    endtask : frame
    // short low pulse on chip select, too short to be a frame
    task glitch(input int w);
        while (idle_cnt < 50) @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        repeat (w) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
    endtask : glitch
endmodule : host_model

// ===== tb_top.sv
// self-checking bench: host model drives frames, a queue predicts results
// assumes the design files and host_model.sv are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: %0h vs %0h", $time, (g), (e)); end end
module tb_top;
    import serial_adc_pkg::*;
    logic ref_clk_i;
    logic rst_n_i;
    logic io_clk, cs_n, addr_in, comp, host_mode, data_o, data_oe_o, sample_o, busy_o, seen_oe;
    wire dout_w;
    chan_sel_t chan_o;
    result_t dac_code_o;
    logic [7:0] vin;
    logic [7:0] exp_q[$];
    int err_total, total_checks, seed;
    // a released output floats, so a stale bit can never pass as data
    assign dout_w = data_oe_o ? data_o : 1'bz;
    // ideal comparator against the analog level held in vin
    assign comp = (vin >= dac_code_o);
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) if (data_oe_o === 1'b1) seen_oe <= 1'b1;
    serial_adc_ctl serial_adc_ctl_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .io_clk_i(io_clk),
        .cs_n_i(cs_n), .addr_in_i(addr_in), .data_o(data_o), .data_oe_o(data_oe_o), .comp_i(comp),
        .sh_host_mode_i(host_mode), .chan_o(chan_o), .sample_o(sample_o), .dac_code_o(dac_code_o),
        .busy_o(busy_o));
    host_model host_model_inst (.ref_clk_i(ref_clk_i), .data_i(dout_w), .io_clk_o(io_clk),
        .cs_n_o(cs_n), .addr_o(addr_in));
    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // bounded wait for busy to reach a level; cnt is the edges it took
    task wait_busy(input logic lvl, input int lim, output int cnt);
        for (cnt = 0; cnt < lim && busy_o !== lvl; cnt++) begin
            @(posedge ref_clk_i);
            #1;
        end
        `CHK(busy_o, lvl)
    endtask : wait_busy
    task run_frame(input logic [7:0] tx, input int n, input logic [7:0] v, input logic hm);
        logic [7:0] rx;
        int sh;
        int cnt;
        chan_sel_t ec;
        sh = (n < 7) ? 7 - n : 0;
        ec = (tx[7:3] < 5'h13) ? chan_sel_t'({tx[7:3], 1'b0}) : chan_sel_t'(6'h01);
        @(posedge ref_clk_i);
        vin <= v;
        host_mode <= hm;
        fork
            host_model_inst.frame(tx, n, rx);
            begin
                // look just after the edge, never in the step that launches oe
                while (data_oe_o !== 1'b1) begin
                    @(posedge ref_clk_i);
                    #1;
                end
                repeat (3) @(posedge ref_clk_i);
                #1;
                if (hm) `CHK(sample_o, 1'b1)
            end
        join
        `CHK(rx >> sh, exp_q[0] >> sh)
        if (n == 8) begin
            wait_busy(1'b1, 20, cnt);
            `CHK(chan_o, ec)
            if (!hm) `CHK(sample_o, 1'b1)
            wait_busy(1'b0, 60, cnt);
            `CHK(cnt >= 36 && cnt <= 38, 1'b1)
            `CHK(dac_code_o, v)
            void'(exp_q.pop_front());
            exp_q.push_back(v);
        end else begin
            repeat (40) @(posedge ref_clk_i);
            #1;
            `CHK(busy_o, 1'b0)
        end
        repeat (10) @(posedge ref_clk_i);
        #1;
        `CHK(data_oe_o, 1'b0)
    endtask : run_frame
    // watchdog: every test together needs well under a millisecond
    initial begin
        #1000000;
        err_total++;
        $display("unexpected at %0t: %0h vs %0h", $time, 0, 1);
        give_verdict();
    end
    initial begin
        logic [4:0] atab[6];
        logic [7:0] tx;
        err_total = 0;
        total_checks = 0;
        seed = 7919;
        rst_n_i = 1'b0;
        vin = 8'h00;
        host_mode = 1'b0;
        seen_oe = 1'b0;
        exp_q.push_back(8'h00);
        atab = '{5'h00, 5'h12, 5'h13, 5'h1F, 5'h05, 5'h0A};
        // reset is longer than two cycles so the io side sees it too
        fork
            host_model_inst.reset_clk();
            repeat (6) @(posedge ref_clk_i);
        join
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK(data_oe_o, 1'b0)
        `CHK(busy_o, 1'b0)
        `CHK(dac_code_o, 8'h00)
        // the io side leaves reset only on shift clock edges after release,
        // so give it four shift clock pulses with chip select high before the first frame
        host_model_inst.reset_clk();
        // channel edge cases either side of the self-test boundary
        for (int k = 0; k < 6; k++) begin
            tx = {atab[k], 3'($random(seed))};
            run_frame(tx, 8, 8'($random(seed)), k[0]);
            $display("test frame %0d done", k);
        end
        run_frame(8'h2C, 4, 8'h00, 1'b0);
        $display("test short frame done");
        seen_oe = 1'b0;
        host_model_inst.glitch(2);
        repeat (10) @(posedge ref_clk_i);
        #1;
        `CHK(seen_oe, 1'b0)
        $display("test glitch done");
        run_frame(8'h08, 8, 8'hFF, 1'b0);
        run_frame(8'h10, 8, 8'h01, 1'b1);
        $display("test final frames done");
        give_verdict();
    end
endmodule : tb_top
